// File: logic/bal_byte_alu.sv
// Byte ALU top: operation sequencing, condition flags and APB registers.
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`include "bal_map.svh"
module bal_byte_alu
	import bal_pkg::*;
(
	input  logic        ref_clk_i,
	input  logic        rst_i,
	input  logic        psel_i,
	input  logic        penable_i,
	input  logic        pwrite_i,
	input  logic [11:0] paddr_i,
	input  logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic        pready_o,
	output logic        pslverr_o,
	input  logic        op_valid_i,
	input  logic [7:0]  opcode_i,
	input  logic [7:0]  accumulator_first_i,
	input  logic [7:0]  operand_second_i,
	input  logic        irq_i,
	input  logic        set_irq_mask_op_i,
	input  logic        clear_irq_mask_op_i,
	output logic        op_ready_o,
	output logic        busy_o,
	output logic        done_o,
	output logic [7:0]  result_o,
	output logic [5:0]  condition_flags_o
);
	localparam bal_regs_t RST_STATE = '{
		fsm:             BAL_IDLE,
		cnt:             3'h0,
		op:              BAL_NONE,
		opnd_a:          8'h00,
		opnd_b:          8'h00,
		condition_flags: `BAL_FLAGS_RST,
		result:          8'h00,
		done:            1'b0,
		illegal:         1'b0,
		rdata:           32'h0000_0000,
		rerr:            1'b0
	};

	bal_regs_t st;
	bal_regs_t next_st;
	logic      wr_flags;
	logic      acc_phase;

	bal_alu_if alu ();

	function automatic bal_op_t decode_op(input logic [7:0] opc);
		bal_op_t o;
		o = BAL_NONE;
		if (opc == `BAL_OPC_ADD_ACC) begin
			o = BAL_ADD;
		end else if (opc == `BAL_OPC_SUB_ACC) begin
			o = BAL_SUB;
		end else if (opc == `BAL_OPC_DECADJ) begin
			o = BAL_DECADJ;
		end else if (opc[7:4] >= `BAL_GRP_INH_A &&
			opc[7:4] <= `BAL_GRP_EXT) begin
			case (opc[3:0])
				`BAL_LO_NEGATE: o = BAL_NEGATE;
				`BAL_LO_INVERT: o = BAL_INVERT;
				`BAL_LO_LSR:    o = BAL_LSR;
				`BAL_LO_ROR:    o = BAL_ROR;
				`BAL_LO_ASR:    o = BAL_ASR;
				`BAL_LO_ASL:    o = BAL_ASL;
				`BAL_LO_ROL:    o = BAL_ROL;
				default:        o = BAL_NONE;
			endcase
		end else if (opc[7]) begin
			case (opc[3:0])
				`BAL_LO_SUB:  o = BAL_SUB;
				`BAL_LO_SUBC: o = BAL_SUBC;
				`BAL_LO_ADDC: o = BAL_ADDC;
				`BAL_LO_ADD:  o = BAL_ADD;
				default:      o = BAL_NONE;
			endcase
		end
		return o;
	endfunction

	function automatic logic [2:0] decode_cycles(input logic [7:0] opc);
		logic [2:0] n;
		n = `BAL_CYC_INH;
		if (opc[7]) begin
			unique case (opc[5:4])
				`BAL_MODE_IMM: n = `BAL_CYC_IMM;
				`BAL_MODE_DIR: n = `BAL_CYC_DIR;
				`BAL_MODE_IDX: n = `BAL_CYC_IDX;
				`BAL_MODE_EXT: n = `BAL_CYC_EXT;
			endcase
		end else if (opc[7:4] == `BAL_GRP_IDX) begin
			n = `BAL_CYC_RMW_IDX;
		end else if (opc[7:4] == `BAL_GRP_EXT) begin
			n = `BAL_CYC_RMW_EXT;
		end
		return n;
	endfunction

	function automatic logic addr_hit(input logic [11:0] addr,
		input logic [11:0] ofs);
		return addr == ofs;
	endfunction

	bal_dec_adjust u_dec_adjust (
		.value_i (st.opnd_a),
		.carry_i (st.condition_flags.c),
		.half_i  (st.condition_flags.h),
		.value_o (alu.adj_value),
		.carry_o (alu.adj_carry)
	);

	bal_alu_core u_core (
		.bus (alu.core)
	);

	assign alu.op       = st.op;
	assign alu.opnd_a   = st.opnd_a;
	assign alu.opnd_b   = st.opnd_b;
	assign alu.flags_in = st.condition_flags;

	assign acc_phase = psel_i && penable_i;
	assign wr_flags  = acc_phase && pwrite_i &&
		addr_hit(paddr_i, `BAL_OFS_FLAGS);

	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		// Read data is loaded in the setup phase so it is steady in access.
		if (psel_i && !penable_i) begin
			next_st.rdata = 32'h0000_0000;
			next_st.rerr = 1'b1;
			if (addr_hit(paddr_i, `BAL_OFS_FLAGS)) begin
				next_st.rdata[`BAL_FLAGS_W-1:0] = st.condition_flags;
				next_st.rerr = 1'b0;
			end
			if (addr_hit(paddr_i, `BAL_OFS_RESULT)) begin
				next_st.rdata[7:0] = st.result;
				next_st.rerr = 1'b0;
			end
			if (addr_hit(paddr_i, `BAL_OFS_STATUS)) begin
				next_st.rdata[`BAL_STAT_BUSY] = (st.fsm == BAL_RUN);
				next_st.rdata[`BAL_STAT_ILL] = st.illegal;
				next_st.rerr = 1'b0;
			end
		end
		if (wr_flags) begin
			next_st.condition_flags = pwdata_i[`BAL_FLAGS_W-1:0];
		end
		unique case (st.fsm)
			BAL_IDLE: begin
				if (op_valid_i) begin
					next_st.op = decode_op(opcode_i);
					next_st.cnt = decode_cycles(opcode_i);
					next_st.opnd_a = accumulator_first_i;
					next_st.opnd_b = operand_second_i;
					next_st.illegal = (decode_op(opcode_i) == BAL_NONE);
					next_st.fsm = BAL_RUN;
				end
			end
			BAL_RUN: begin
				next_st.cnt = st.cnt - 3'h1;
				// Completion of a legal operation wins over a flag write in the same cycle.
				if (st.cnt == `BAL_CNT_LAST) begin
					next_st.fsm = BAL_IDLE;
					next_st.done = 1'b1;
					if (!st.illegal) begin
						next_st.result = alu.result;
						next_st.condition_flags = alu.flags_out;
					end
				end
			end
		endcase
		// Mask events come last so they beat both writes and results.
		if (irq_i || set_irq_mask_op_i) begin
			next_st.condition_flags.i = 1'b1;
		end else if (clear_irq_mask_op_i) begin
			next_st.condition_flags.i = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			st <= RST_STATE;
		end else begin
			st <= next_st;
		end
	end

	assign prdata_o          = st.rdata;
	assign pready_o          = acc_phase;
	assign pslverr_o         = acc_phase && st.rerr;
	assign op_ready_o        = (st.fsm == BAL_IDLE);
	assign busy_o            = (st.fsm == BAL_RUN);
	assign done_o            = st.done;
	assign result_o          = st.result;
	assign condition_flags_o = st.condition_flags;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);

	logic       fin;
	logic [8:0] ref_sum;
	logic [4:0] ref_low;
	assign fin = done_o && !st.illegal;
	assign ref_sum = {1'b0, st.opnd_a} + {1'b0, st.opnd_b};
	assign ref_low = {1'b0, st.opnd_a[3:0]} + {1'b0, st.opnd_b[3:0]};

	sequence s_take_inh;
		op_valid_i && op_ready_o && opcode_i[7:4] == `BAL_GRP_INH_A;
	endsequence
	sequence s_take_idx;
		op_valid_i && op_ready_o && opcode_i[7:4] == `BAL_GRP_IDX;
	endsequence
	sequence s_run_two;
		busy_o ##1 (done_o && !busy_o);
	endsequence
	sequence s_run_seven;
		busy_o [*6] ##1 (done_o && !busy_o);
	endsequence

	inh_timing_a: assert property (
		s_take_inh |=> s_run_two)
		else $error("inherent op did not take two cycles");
	rmw_timing_a: assert property (
		s_take_idx |=> s_run_seven)
		else $error("indexed memory op did not take seven cycles");
	neg_flag_a: assert property (
		fin |-> condition_flags_o[3] == result_o[7])
		else $error("negative flag differs from result bit 7");
	zero_flag_a: assert property (
		fin |-> condition_flags_o[2] == (result_o == 8'h00))
		else $error("zero flag does not match result");
	add_sum_a: assert property (
		fin && st.op == BAL_ADD |->
		{condition_flags_o[0], result_o} == ref_sum &&
		condition_flags_o[5] == ref_low[4])
		else $error("add result, carry or half carry wrong");
	add_ovf_a: assert property (
		fin && st.op inside {BAL_ADD, BAL_ADDC} |->
		condition_flags_o[1] == (st.opnd_a[7] == st.opnd_b[7] &&
		result_o[7] != st.opnd_a[7]))
		else $error("add overflow flag wrong");
	sub_ovf_a: assert property (
		fin && st.op inside {BAL_SUB, BAL_SUBC} |->
		condition_flags_o[1] == (st.opnd_a[7] != st.opnd_b[7] &&
		result_o[7] != st.opnd_a[7]))
		else $error("subtract overflow flag wrong");
	shift_ovf_a: assert property (
		fin && st.op inside {BAL_LSR, BAL_ROR, BAL_ASR, BAL_ASL,
		BAL_ROL} |-> condition_flags_o[1] ==
		(condition_flags_o[3] ^ condition_flags_o[0]))
		else $error("shift overflow is not N xor C");
	invert_flags_a: assert property (
		fin && st.op == BAL_INVERT |-> result_o == ~st.opnd_a &&
		!condition_flags_o[1] && condition_flags_o[0])
		else $error("invert result or flags wrong");
	negate_flags_a: assert property (
		fin && st.op == BAL_NEGATE |->
		result_o == 8'h00 - st.opnd_a &&
		condition_flags_o[1] == (result_o == `BAL_NEG_OVF) &&
		condition_flags_o[0] == (result_o != 8'h00))
		else $error("negate result or flags wrong");
	mask_hold_a: assert property (
		!irq_i && !set_irq_mask_op_i && !clear_irq_mask_op_i &&
		!wr_flags |=> $stable(condition_flags_o[4]))
		else $error("interrupt mask changed without cause");
	decadj_carry_a: assert property (
		fin && st.op == BAL_DECADJ &&
		st.opnd_a[7:4] > `BAL_BCD_MAX |-> condition_flags_o[0])
		else $error("decimal adjust did not set carry");
endmodule

// File: logic/bal_map.svh
// Register offsets, field positions, reset values and cycle counts.
// Functional notes
// - Every sum is plain 8-bit binary addition.
// - Subtract adds the subtrahend's two's complement.
// - H is the carry from bit 3.
// - I set by interrupt/set-mask, cleared by clear-mask.
// - N copies result bit 7.
// - Z set when the result is zero.
// - Add overflow: like signs, result sign differs.
// - Subtract overflow: unlike signs, result sign flips.
// - C is the carry out of bit 7.
// - Carry is borrow; add/subtract with carry use it.
// - Shift and rotate: V equals N xor C.
// - Unary opcodes 4x, 5x, 6x, 7x decode fixed.
// - Cycle counts per addressing mode as specified.
// - Decimal adjust 19 corrects A and carry.
// - Decimal adjust adds 00, 06, 60 or 66.
// - Both nibbles decimal, no carries: add 00.
// - Low nibble correction adds 06, carry clear.
// - High nibble correction adds 60/66, sets carry.
// - Carry already set: add 60/66, carry stays.
// - Decimal adjust keeps H and I, updates N, Z.
`ifndef BAL_MAP_SVH
`define BAL_MAP_SVH
`define BAL_OFS_FLAGS   12'h000
`define BAL_OFS_RESULT  12'h004
`define BAL_OFS_STATUS  12'h008
`define BAL_STAT_BUSY   0
`define BAL_STAT_ILL    1
`define BAL_FLAGS_W     6
`define BAL_FLAGS_RST   6'h10
`define BAL_CYC_IMM     3'h2
`define BAL_CYC_DIR     3'h3
`define BAL_CYC_IDX     3'h5
`define BAL_CYC_EXT     3'h4
`define BAL_CYC_INH     3'h2
`define BAL_CYC_RMW_IDX 3'h7
`define BAL_CYC_RMW_EXT 3'h6
`define BAL_CNT_LAST    3'h2
`define BAL_MODE_IMM    2'h0
`define BAL_MODE_DIR    2'h1
`define BAL_MODE_IDX    2'h2
`define BAL_MODE_EXT    2'h3
`define BAL_GRP_INH_A   4'h4
`define BAL_GRP_IDX     4'h6
`define BAL_GRP_EXT     4'h7
`define BAL_OPC_ADD_ACC 8'h1b
`define BAL_OPC_SUB_ACC 8'h10
`define BAL_OPC_DECADJ  8'h19
`define BAL_LO_NEGATE   4'h0
`define BAL_LO_INVERT   4'h3
`define BAL_LO_LSR      4'h4
`define BAL_LO_ROR      4'h6
`define BAL_LO_ASR      4'h7
`define BAL_LO_ASL      4'h8
`define BAL_LO_ROL      4'h9
`define BAL_LO_SUB      4'h0
`define BAL_LO_SUBC     4'h2
`define BAL_LO_ADDC     4'h9
`define BAL_LO_ADD      4'hb
`define BAL_NEG_OVF     8'h80
`define BAL_BCD_MAX     4'h9
`define BAL_BCD_FIX     4'h6
`endif

// File: logic/bal_pkg.sv
// Types shared by the byte ALU modules.
package bal_pkg;
	typedef enum logic [3:0] {
		BAL_NONE, BAL_ADD, BAL_ADDC, BAL_SUB, BAL_SUBC, BAL_NEGATE,
		BAL_INVERT, BAL_LSR, BAL_ROR, BAL_ASR, BAL_ASL, BAL_ROL,
		BAL_DECADJ
	} bal_op_t;
	typedef enum logic {BAL_IDLE, BAL_RUN} bal_state_t;
	typedef struct packed {
		logic h;
		logic i;
		logic n;
		logic z;
		logic v;
		logic c;
	} bal_flags_t;
	typedef struct packed {
		bal_state_t  fsm;
		logic [2:0]  cnt;
		bal_op_t     op;
		logic [7:0]  opnd_a;
		logic [7:0]  opnd_b;
		bal_flags_t  condition_flags;
		logic [7:0]  result;
		logic        done;
		logic        illegal;
		logic [31:0] rdata;
		logic        rerr;
	} bal_regs_t;
endpackage

// File: logic/bal_alu_if.sv
// Operand, flag and result bundle between sequencer and ALU core.
`timescale 1ns/10ps
interface bal_alu_if;
	import bal_pkg::*;
	bal_op_t    op;
	logic [7:0] opnd_a;
	logic [7:0] opnd_b;
	bal_flags_t flags_in;
	logic [7:0] adj_value;
	logic       adj_carry;
	logic [7:0] result;
	bal_flags_t flags_out;
	modport core (input op, opnd_a, opnd_b, flags_in, adj_value,
		adj_carry, output result, flags_out);
	modport user (output op, opnd_a, opnd_b, flags_in, adj_value,
		adj_carry, input result, flags_out);
endinterface

// File: logic/bal_dec_adjust.sv
// Decimal adjust correction of a binary sum of two packed BCD bytes.
`timescale 1ns/10ps
`include "bal_map.svh"
module bal_dec_adjust (
	input  logic [7:0] value_i,
	input  logic       carry_i,
	input  logic       half_i,
	output logic [7:0] value_o,
	output logic       carry_o
);
	logic lo_fix;
	logic hi_fix;

	// Two compares on the high nibble and one on the low nibble cover every row of the correction table.
	always_comb begin
		lo_fix = half_i || (value_i[3:0] > `BAL_BCD_MAX);
		hi_fix = carry_i || (value_i[7:4] > `BAL_BCD_MAX) ||
			((value_i[7:4] >= `BAL_BCD_MAX) &&
			(value_i[3:0] > `BAL_BCD_MAX));
		value_o = value_i + {(hi_fix ? `BAL_BCD_FIX : 4'h0),
			(lo_fix ? `BAL_BCD_FIX : 4'h0)};
		carry_o = carry_i || hi_fix;
	end
endmodule

// File: logic/bal_alu_core.sv
// Combinational adder, shifter and flag logic of the byte ALU.
`timescale 1ns/10ps
`include "bal_map.svh"
module bal_alu_core
	import bal_pkg::*;
(
	bal_alu_if.core bus
);
	logic [7:0] x;
	logic [7:0] y;
	logic       cin;
	logic [8:0] sum;
	logic [4:0] low;
	logic [7:0] r;
	bal_flags_t f;

	always_comb begin
		x = bus.opnd_a;
		y = bus.opnd_b;
		cin = 1'b0;
		f = bus.flags_in;
		r = bus.opnd_a;
		case (bus.op)
			BAL_ADDC: cin = bus.flags_in.c;
			BAL_SUB: begin
				y = ~bus.opnd_b;
				cin = 1'b1;
			end
			BAL_SUBC: begin
				y = ~bus.opnd_b;
				cin = ~bus.flags_in.c;
			end
			BAL_NEGATE: begin
				x = 8'h00;
				y = ~bus.opnd_a;
				cin = 1'b1;
			end
			default: ;
		endcase
		sum = {1'b0, x} + {1'b0, y} + {8'h00, cin};
		low = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
		case (bus.op)
			BAL_ADD, BAL_ADDC: begin
				r = sum[7:0];
				f.h = low[4];
				f.c = sum[8];
				f.v = (x[7] == y[7]) && (r[7] != x[7]);
			end
			BAL_SUB, BAL_SUBC: begin
				r = sum[7:0];
				f.c = ~sum[8];
				f.v = (x[7] == y[7]) && (r[7] != x[7]);
			end
			BAL_NEGATE: begin
				r = sum[7:0];
				f.v = (r == `BAL_NEG_OVF);
				f.c = (r != 8'h00);
			end
			BAL_INVERT: begin
				r = ~bus.opnd_a;
				f.v = 1'b0;
				f.c = 1'b1;
			end
			BAL_LSR: {r, f.c} = {1'b0, bus.opnd_a};
			BAL_ROR: {r, f.c} = {bus.flags_in.c, bus.opnd_a};
			BAL_ASR: {r, f.c} = {bus.opnd_a[7], bus.opnd_a};
			BAL_ASL: {f.c, r} = {bus.opnd_a, 1'b0};
			BAL_ROL: {f.c, r} = {bus.opnd_a, bus.flags_in.c};
			BAL_DECADJ: begin
				r = bus.adj_value;
				f.c = bus.adj_carry;
			end
			default: ;
		endcase
		if (bus.op != BAL_NONE) begin
			f.n = r[7];
			f.z = (r == 8'h00);
		end
		if (bus.op inside {BAL_LSR, BAL_ROR, BAL_ASR, BAL_ASL, BAL_ROL}) begin
			f.v = f.n ^ f.c;
		end
		bus.result = r;
		bus.flags_out = f;
	end
endmodule

// File: tb/bal_seq_model.sv
// Model of the sequencer that hands operations and operands to the ALU.
`timescale 1ns/10ps
module bal_seq_model (
	input  wire logic       ref_clk_i,
	input  wire logic       op_ready_i,
	output logic            op_valid_o,
	output logic [7:0]      opcode_o,
	output logic [7:0]      acc_o,
	output logic [7:0]      opnd_o
);
	initial begin
		op_valid_o = 1'b0;
		opcode_o = 8'h01;
		acc_o = 8'h00;
		opnd_o = 8'h00;
	end

	// Called just after a rising edge; returns just after the taking edge.
	task automatic issue(input logic [7:0] opc, a, b, output logic ok);
		int n;
		n = 0;
		op_valid_o <= 1'b1;
		opcode_o <= opc;
		acc_o <= a;
		opnd_o <= b;
		do begin
			@(negedge ref_clk_i);
			n++;
		end while (op_ready_i !== 1'b1 && n < 50);
		ok = (op_ready_i === 1'b1);
		@(posedge ref_clk_i);
	endtask

	// Released lines flip, so stale operands can never look valid.
	task automatic release_req();
		op_valid_o <= 1'b0;
		opcode_o <= ~opcode_o;
		acc_o <= ~acc_o;
		opnd_o <= ~opnd_o;
	endtask
endmodule

// File: tb/bal_byte_alu_tb.sv
// Self-checking bench for the byte ALU: registers, masks and operations.
`timescale 1ns/10ps
`include "bal_map.svh"
module bal_byte_alu_tb
	import bal_pkg::*;
;
	typedef struct packed {
		logic [7:0] res;
		bal_flags_t flg;
		logic [3:0] cyc;
	} bal_note_t;
	localparam int N_OPS = 43;
	logic [7:0]  ops [N_OPS] = '{
		8'h8b, 8'h89, 8'h80, 8'h82, 8'h1b, 8'h10, 8'h9b, 8'hab, 8'hbb,
		8'hcb, 8'hc0, 8'hd2, 8'he9, 8'hf0, 8'h40, 8'h43, 8'h44, 8'h46,
		8'h47, 8'h48, 8'h49, 8'h50, 8'h53, 8'h54, 8'h56, 8'h57, 8'h58,
		8'h59, 8'h60, 8'h63, 8'h64, 8'h66, 8'h67, 8'h68, 8'h69, 8'h70,
		8'h73, 8'h74, 8'h76, 8'h77, 8'h78, 8'h79, 8'h19};
	logic        ref_clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        psel_i = 1'b0;
	logic        penable_i = 1'b0;
	logic        pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0000_0000;
	logic [31:0] prdata_o;
	logic        pready_o;
	logic        pslverr_o;
	logic        op_valid_i;
	logic [7:0]  opcode_i;
	logic [7:0]  accumulator_first_i;
	logic [7:0]  operand_second_i;
	logic        irq_i = 1'b0;
	logic        set_irq_mask_op_i = 1'b0;
	logic        clear_irq_mask_op_i = 1'b0;
	logic        op_ready_o;
	logic        busy_o;
	logic        done_o;
	logic [7:0]  result_o;
	logic [5:0]  condition_flags_o;
	bal_note_t   notes [$];
	bal_note_t   got;
	bal_flags_t  exp_flg;
	logic [7:0]  exp_res = 8'h00;
	logic [3:0]  cnt = 4'h0;
	logic [31:0] rd;
	logic [31:0] rv;
	logic        er;
	logic [2:0]  mk [5] = '{3'b100, 3'b001, 3'b011, 3'b001, 3'b010};
	int          n_errors = 0;
	int          total_checks = 0;

	always #25 ref_clk_i = ~ref_clk_i;

	bal_byte_alu dut (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .op_valid_i(op_valid_i),
		.opcode_i(opcode_i), .accumulator_first_i(accumulator_first_i),
		.operand_second_i(operand_second_i), .irq_i(irq_i),
		.set_irq_mask_op_i(set_irq_mask_op_i),
		.clear_irq_mask_op_i(clear_irq_mask_op_i),
		.op_ready_o(op_ready_o), .busy_o(busy_o), .done_o(done_o),
		.result_o(result_o), .condition_flags_o(condition_flags_o));

	bal_seq_model seq (
		.ref_clk_i(ref_clk_i), .op_ready_i(op_ready_o),
		.op_valid_o(op_valid_i), .opcode_o(opcode_i),
		.acc_o(accumulator_first_i), .opnd_o(operand_second_i));

	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic hung();
		n_errors++;
		$display("mismatch handshake expected answer seen timeout");
		finish_test();
	endtask

	task automatic chk_reg(input string nm, input logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_op(input bal_note_t e, g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch operation expected %h seen %h", e, g);
		end
	endtask

	// Expected result, flags and length of one operation.
	function automatic void ref_op(input logic [7:0] op, a, b,
			inout logic [7:0] r, inout bal_flags_t f, output int cyc);
		logic [8:0] s;
		logic [4:0] hs;
		logic       ci;
		logic       ok;
		logic       sh;
		ok = 1'b1;
		sh = 1'b0;
		s = 9'h000;
		case (op[7:4])
			4'h9, 4'hd: cyc = 3;
			4'ha, 4'he: cyc = 5;
			4'hb, 4'hf: cyc = 4;
			4'h6: cyc = 7;
			4'h7: cyc = 6;
			default: cyc = 2;
		endcase
		if (op == 8'h1b || (op[7] && op[3:0] inside {4'h9, 4'hb})) begin
			ci = (op[3:0] == 4'h9) ? f.c : 1'b0;
			s = a + b + ci;
			hs = a[3:0] + b[3:0] + ci;
			f.h = hs[4];
			f.v = (a[7] == b[7]) && (s[7] != a[7]);
		end else if (op == 8'h10 || (op[7] && op[3:0] inside {4'h0, 4'h2}))
				begin
			ci = (op[3:0] == 4'h2) ? f.c : 1'b0;
			s = a - b - ci;
			f.v = (a[7] != b[7]) && (s[7] != a[7]);
		end else if (op == 8'h19) begin
			ci = f.h || a[3:0] > 4'h9;
			sh = f.c || a[7:4] > 4'h9 || (a[7:4] >= 4'h9 && a[3:0] > 4'h9);
			s = {sh, a + {sh ? 4'h6 : 4'h0, ci ? 4'h6 : 4'h0}};
			sh = 1'b0;
		end else if (op[7:4] inside {[4'h4:4'h7]}) begin
			sh = op[3:0] inside {4'h4, 4'h6, 4'h7, 4'h8, 4'h9};
			case (op[3:0])
				4'h0: s = {a != 8'h00, 8'h00 - a};
				4'h3: s = {1'b1, ~a};
				4'h4: s = {a[0], 1'b0, a[7:1]};
				4'h6: s = {a[0], f.c, a[7:1]};
				4'h7: s = {a[0], a[7], a[7:1]};
				4'h8: s = {a, 1'b0};
				4'h9: s = {a, f.c};
				default: ok = 1'b0;
			endcase
			if (op[3:0] inside {4'h0, 4'h3})
				f.v = (op[3:0] == 4'h0) && (s[7:0] == 8'h80);
		end else
			ok = 1'b0;
		if (ok) begin
			r = s[7:0];
			f.n = s[7];
			f.z = (s[7:0] == 8'h00);
			f.c = s[8];
			if (sh)
				f.v = s[7] ^ s[8];
		end
	endfunction

	task automatic apb(input logic wr, input logic [11:0] ad,
			input logic [31:0] wd, output logic [31:0] rdv, output logic erv);
		int n;
		n = 0;
		@(posedge ref_clk_i);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= ad;
		pwdata_i <= wd;
		@(posedge ref_clk_i);
		penable_i <= 1'b1;
		// Ready, read data and error are all taken at the same rising edge.
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 20);
		if (n >= 20)
			hung();
		rdv = prdata_o;
		erv = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	task automatic do_op(input logic [7:0] opc, a, b);
		int  cy;
		logic ok;
		ref_op(opc, a, b, exp_res, exp_flg, cy);
		notes.push_back({exp_res, exp_flg, cy[3:0]});
		seq.issue(opc, a, b, ok);
		if (!ok)
			hung();
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			@(negedge ref_clk_i);
			n++;
		end while ((notes.size() != 0 || op_ready_o !== 1'b1) && n < 100);
		if (n >= 100)
			hung();
		@(posedge ref_clk_i);
	endtask

	// The count is checked before a new take restarts it.
	always @(negedge ref_clk_i) begin
		if (done_o === 1'b1) begin
			got = {result_o, condition_flags_o, cnt};
			chk_reg("busy_o", 32'h0, {31'h0, busy_o});
			if (notes.size() == 0)
				chk_reg("done_o", 32'h0, 32'h1);
			else
				chk_op(notes.pop_front(), got);
		end
		// The take cycle itself counts as the first cycle of the operation.
		if (op_valid_i === 1'b1 && op_ready_o === 1'b1)
			cnt = 4'h1;
		else if (cnt != 4'hf)
			cnt = cnt + 4'h1;
	end

	initial begin
		rv = $urandom(32'ha8a0);
		repeat (10) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		@(posedge ref_clk_i);
		apb(1'b0, `BAL_OFS_FLAGS, 32'h0, rd, er);
		chk_reg("flags", {26'h0, `BAL_FLAGS_RST}, rd);
		apb(1'b1, `BAL_OFS_FLAGS, 32'h0000_002a, rd, er);
		apb(1'b1, `BAL_OFS_RESULT, 32'h0000_00ff, rd, er);
		apb(1'b0, `BAL_OFS_RESULT, 32'h0, rd, er);
		chk_reg("result", 32'h0, rd);
		apb(1'b0, 12'h00c, 32'h0, rd, er);
		chk_reg("slverr", 32'h1, {31'h0, er});
		exp_flg = 6'h2a;
		foreach (mk[k]) begin
			@(posedge ref_clk_i);
			{irq_i, set_irq_mask_op_i, clear_irq_mask_op_i} <= mk[k];
			@(posedge ref_clk_i);
			{irq_i, set_irq_mask_op_i, clear_irq_mask_op_i} <= 3'b000;
			exp_flg.i = mk[k][2] | mk[k][1];
			apb(1'b0, `BAL_OFS_FLAGS, 32'h0, rd, er);
			chk_reg("mask", {26'h0, exp_flg}, rd);
		end
		foreach (ops[k]) begin
			repeat (8) begin
				rv = $urandom;
				exp_flg = rv[29:24];
				apb(1'b1, `BAL_OFS_FLAGS, {26'h0, rv[29:24]}, rd, er);
				do_op(ops[k], rv[7:0], rv[15:8]);
				seq.release_req();
				wait_idle();
			end
		end
		// Back to back, so each take after the first lands on the edge ending done.
		@(posedge ref_clk_i);
		repeat (12) begin
			rv = $urandom;
			do_op(ops[int'(rv[23:16]) % N_OPS], rv[7:0], rv[15:8]);
		end
		do_op(8'h41, 8'h5a, 8'ha5);
		seq.release_req();
		wait_idle();
		apb(1'b0, `BAL_OFS_STATUS, 32'h0, rd, er);
		chk_reg("status", 32'h0000_0002, rd);
		apb(1'b0, `BAL_OFS_RESULT, 32'h0, rd, er);
		chk_reg("result", {24'h0, exp_res}, rd);
		finish_test();
	end
endmodule
